// [src/video_in_defs.svh]
`ifndef VIDEO_IN_DEFS_SVH
`define VIDEO_IN_DEFS_SVH

// ---------------------------------------------------------------
// input format select codes
// ---------------------------------------------------------------
`define FMT_YUV411_SERIAL 3'h0
`define FMT_YUV411_WORD   3'h1
`define FMT_YUV422_MUX    3'h2
`define FMT_YUV422_PAR    3'h3
`define FMT_YUV444        3'h4
`define FMT_RGB444        3'h5
`define FMT_RESERVED      3'h6
`define FMT_INDEXED       3'h7

// ---------------------------------------------------------------
// widths and counts
// ---------------------------------------------------------------
`define PIX_W             8
`define RT_W              22
`define ACC_W             32
`define PHASE_OUT_W       12
`define GROUP_LEN         4
`define PAL_FIELD_SEQ     8
`define NTSC_FIELD_SEQ    4
`define FIELD_CNT_W       3
`define OFFSET_SHIFT      8
`define LINES_625         625
`define LINES_525         525

`endif

// [src/video_in_pkg.sv]
package video_in_pkg;

  typedef enum logic [2:0] {
    FMT_YUV411_SERIAL = 3'h0,
    FMT_YUV411_WORD   = 3'h1,
    FMT_YUV422_MUX    = 3'h2,
    FMT_YUV422_PAR    = 3'h3,
    FMT_YUV444        = 3'h4,
    FMT_RGB444        = 3'h5,
    FMT_RESERVED      = 3'h6,
    FMT_INDEXED       = 3'h7
  } fmt_t;

  typedef enum logic [1:0] {
    SC_INTERNAL = 2'b00,
    SC_EXTERNAL = 2'b01,
    SC_HPLL     = 2'b10,
    SC_GENLOCK  = 2'b11
  } sc_src_t;

endpackage

// [src/pixel_link_if.sv]
`timescale 1ns/1ns
`include "video_in_defs.svh"

interface pixel_link_if;
  logic                 pixel_valid;
  logic                 pixel_ready;
  logic                 group_first;
  logic [`PIX_W-1:0]    pixel_port_a;
  logic [`PIX_W-1:0]    pixel_port_b;
  logic [`PIX_W-1:0]    pixel_port_c;
  logic [`RT_W-1:0]     realtime_control_input;
  logic                 realtime_strobe;

  modport source (
    output pixel_valid,
    input  pixel_ready,
    output group_first,
    output pixel_port_a,
    output pixel_port_b,
    output pixel_port_c,
    output realtime_control_input,
    output realtime_strobe
  );

  modport encoder (
    input  pixel_valid,
    output pixel_ready,
    input  group_first,
    input  pixel_port_a,
    input  pixel_port_b,
    input  pixel_port_c,
    input  realtime_control_input,
    input  realtime_strobe
  );
endinterface

// [src/pixel_source_end.sv]
`timescale 1ns/1ns
`include "video_in_defs.svh"

module pixel_source_end
  import video_in_pkg::*;
(
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  // link to the encoder
  pixel_link_if.source           link,
  // user pixel stream
  input  wire logic [2:0]        SRC_FORMAT,
  input  wire logic              SRC_VALID,
  output      logic              SRC_READY,
  input  wire logic              SRC_FIRST,
  input  wire logic [`PIX_W-1:0] SRC_Y,
  input  wire logic [`PIX_W-1:0] SRC_CB,
  input  wire logic [`PIX_W-1:0] SRC_CR,
  // decoder real-time increment
  input  wire logic              SRC_RT_STROBE,
  input  wire logic [`RT_W-1:0]  SRC_RT_WORD
);

  // ---------------------------------------------------------------
  // group position and chroma latches
  // ---------------------------------------------------------------
  logic [1:0]        pos;
  logic [`PIX_W-1:0] cb_lat;
  logic [`PIX_W-1:0] cr_lat;

  wire               load     = !link.pixel_valid || link.pixel_ready;
  wire               take     = load && SRC_VALID;
  wire [1:0]         cur_pos  = SRC_FIRST ? 2'h0 : pos;
  wire               even     = !cur_pos[0];
  wire               pos_zero = (cur_pos == 2'h0);
  wire [`PIX_W-1:0]  cb_sel   = pos_zero ? SRC_CB : cb_lat;
  wire [`PIX_W-1:0]  cr_sel   = pos_zero ? SRC_CR : cr_lat;

  // ---------------------------------------------------------------
  // per-format lane mapping
  // ---------------------------------------------------------------
  logic [`PIX_W-1:0] next_b;
  logic [`PIX_W-1:0] next_c;
  logic [`PIX_W-1:0] next_cb_lat;
  logic [`PIX_W-1:0] next_cr_lat;

  always_comb begin
    next_b      = 8'h00;
    next_c      = 8'h00;
    next_cb_lat = cb_lat;
    next_cr_lat = cr_lat;
    unique case (SRC_FORMAT)
      `FMT_YUV411_SERIAL: begin
        next_b      = {cb_sel[7:6], cr_sel[7:6], 4'h0};
        next_cb_lat = {cb_sel[5:0], 2'b00};
        next_cr_lat = {cr_sel[5:0], 2'b00};
      end
      `FMT_YUV411_WORD: begin
        if (pos_zero) begin
          next_b      = SRC_CB;
          next_cr_lat = SRC_CR;
        end else if (cur_pos == 2'h2) begin
          next_b = cr_lat;
        end
      end
      `FMT_YUV422_MUX: begin
        if (even) begin
          next_b      = SRC_CB;
          next_cr_lat = SRC_CR;
        end else begin
          next_b = cr_lat;
        end
      end
      `FMT_YUV422_PAR: begin
        next_b = even ? SRC_CB : 8'h00;
        next_c = even ? SRC_CR : 8'h00;
      end
      `FMT_YUV444, `FMT_RGB444: begin
        next_b = SRC_CB;
        next_c = SRC_CR;
      end
      default: begin
        next_b = 8'h00;
        next_c = 8'h00;
      end
    endcase
  end

  assign SRC_READY = load;

  // ---------------------------------------------------------------
  // one pixel per accepted cycle
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      link.pixel_valid  <= 1'b0;
      link.group_first  <= 1'b0;
      link.pixel_port_a <= 8'h00;
      link.pixel_port_b <= 8'h00;
      link.pixel_port_c <= 8'h00;
      pos               <= 2'h0;
      cb_lat            <= 8'h00;
      cr_lat            <= 8'h00;
    end else if (load) begin
      link.pixel_valid <= SRC_VALID;
      if (take) begin
        link.group_first  <= pos_zero;
        link.pixel_port_a <= SRC_Y;
        link.pixel_port_b <= next_b;
        link.pixel_port_c <= next_c;
        pos               <= cur_pos + 2'h1;
        cb_lat            <= next_cb_lat;
        cr_lat            <= next_cr_lat;
      end
    end
  end

  // real-time increment is forwarded on its own strobe
  always_ff @(posedge CLK) begin
    if (RESET) begin
      link.realtime_strobe        <= 1'b0;
      link.realtime_control_input <= '0;
    end else begin
      link.realtime_strobe <= SRC_RT_STROBE;
      if (SRC_RT_STROBE) begin
        link.realtime_control_input <= SRC_RT_WORD;
      end
    end
  end

endmodule

// [src/video_input_demux.sv]
`timescale 1ns/1ns
`include "video_in_defs.svh"

module video_input_demux
  import video_in_pkg::*;
#(
  parameter int LINE_PIXELS = 864,
  parameter int N_PAL       = 1135,
  parameter int N_NTSC      = 455,
  parameter int HPLL_MULT   = 1024
)
(
  // clock and reset
  input  wire logic                    CLK,
  input  wire logic                    RESET,
  // link to the pixel source
  pixel_link_if.encoder                link,
  // mode control
  input  wire logic [2:0]              INPUT_FORMAT_SELECT,
  input  wire logic                    GENLOCK_MODE,
  input  wire logic                    SLAVE_MODE,
  input  wire logic                    PAL_MODE,
  input  wire logic                    LINES_625_MODE,
  input  wire logic                    REALTIME_CONTROL_ENABLE,
  input  wire logic                    REALTIME_SUBCARRIER_SELECT,
  input  wire logic [7:0]              SUBCARRIER_FREQ_OFFSET,
  input  wire logic [7:0]              CHROMA_PHASE_BYTE,
  input  wire logic                    FIELD_START,
  // demultiplexed samples
  output      logic                    SAMPLE_VALID,
  input  wire logic                    SAMPLE_READY,
  output      logic [`PIX_W-1:0]       SAMPLE_Y,
  output      logic [`PIX_W-1:0]       SAMPLE_U,
  output      logic [`PIX_W-1:0]       SAMPLE_V,
  output      fmt_t                    SAMPLE_FORMAT,
  output      logic                    FORMAT_RESERVED,
  // subcarrier
  output      logic [`PHASE_OUT_W-1:0] SC_PHASE,
  output      logic                    SC_PHASE_RESET,
  output      sc_src_t                 SC_SOURCE
);

  // ---------------------------------------------------------------
  // subcarrier increments per pixel clock
  // ---------------------------------------------------------------
  localparam longint TWO_32   = 64'h1_0000_0000;
  localparam longint INC_P625 = (TWO_32 * (`LINES_625 * N_PAL + 4))
                                / (4 * `LINES_625 * LINE_PIXELS);
  localparam longint INC_P525 = (TWO_32 * (`LINES_525 * N_PAL + 4))
                                / (4 * `LINES_525 * LINE_PIXELS);
  localparam longint INC_NTSC = (TWO_32 * N_NTSC) / (2 * LINE_PIXELS);
  localparam logic [`ACC_W-1:0] INC_PAL625 = INC_P625[`ACC_W-1:0];
  localparam logic [`ACC_W-1:0] INC_PAL525 = INC_P525[`ACC_W-1:0];
  localparam logic [`ACC_W-1:0] INC_NTSC_W = INC_NTSC[`ACC_W-1:0];
  localparam logic [`ACC_W-1:0] HPLL_MULT_W = HPLL_MULT[`ACC_W-1:0];

  // ---------------------------------------------------------------
  // subcarrier source selection
  // ---------------------------------------------------------------
  logic [`ACC_W-1:0] acc;
  logic [`RT_W-1:0]  rt_word;
  logic [2:0]        field_cnt;
  sc_src_t           next_src;

  wire               offset_zero = (SUBCARRIER_FREQ_OFFSET == 8'h00);
  wire               rt_active   = SLAVE_MODE && REALTIME_CONTROL_ENABLE;
  wire [`ACC_W-1:0]  offset_add  = `ACC_W'({{24{SUBCARRIER_FREQ_OFFSET[7]}},
                                   SUBCARRIER_FREQ_OFFSET} << `OFFSET_SHIFT);
  wire [`ACC_W-1:0]  inc_int     = !PAL_MODE ? INC_NTSC_W
                                 : (LINES_625_MODE ? INC_PAL625 : INC_PAL525);
  wire [2*`ACC_W-1:0] hpll_prod  = {{(`ACC_W-`RT_W){1'b0}}, rt_word} * HPLL_MULT_W;
  wire [`ACC_W-1:0]  inc_ext     = {{(`ACC_W-`RT_W){1'b0}}, rt_word};
  wire [2:0]         seq_last    = PAL_MODE ? 3'(`PAL_FIELD_SEQ - 1)
                                            : 3'(`NTSC_FIELD_SEQ - 1);
  wire               seq_wrap    = FIELD_START && (field_cnt >= seq_last);
  wire               reset_ok    = offset_zero && (next_src != SC_GENLOCK);
  wire               do_reset    = seq_wrap && reset_ok;

  always_comb begin
    if (GENLOCK_MODE) begin
      next_src = SC_GENLOCK;
    end else if (rt_active && REALTIME_SUBCARRIER_SELECT) begin
      next_src = SC_EXTERNAL;
    end else if (rt_active) begin
      next_src = SC_HPLL;
    end else begin
      next_src = SC_INTERNAL;
    end
  end

  logic [`ACC_W-1:0] inc_sel;
  always_comb begin
    unique case (next_src)
      SC_EXTERNAL: inc_sel = inc_ext;
      SC_HPLL:     inc_sel = hpll_prod[`ACC_W-1:0] + offset_add;
      SC_INTERNAL: inc_sel = inc_int + offset_add;
      SC_GENLOCK:  inc_sel = inc_int;
    endcase
  end

  // ---------------------------------------------------------------
  // phase accumulator and field sequence
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rt_word <= '0;
    end else if (link.realtime_strobe) begin
      rt_word <= link.realtime_control_input;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      acc            <= '0;
      field_cnt      <= 3'h0;
      SC_PHASE_RESET <= 1'b0;
      SC_SOURCE      <= SC_INTERNAL;
      SC_PHASE       <= '0;
    end else begin
      SC_SOURCE      <= next_src;
      SC_PHASE_RESET <= do_reset;
      acc            <= do_reset ? '0 : acc + inc_sel;
      if (FIELD_START) begin
        field_cnt <= seq_wrap ? 3'h0 : field_cnt + 3'h1;
      end
      // burst phase offset is added after the accumulator
      SC_PHASE <= acc[`ACC_W-1 -: `PHASE_OUT_W]
                  + {CHROMA_PHASE_BYTE, 4'h0};
    end
  end

  // ---------------------------------------------------------------
  // pixel demultiplexer
  // ---------------------------------------------------------------
  logic [1:0]        pos;
  logic [5:0]        cb_sh;
  logic [5:0]        cr_sh;
  logic [`PIX_W-1:0] cb_pend;
  logic [`PIX_W-1:0] cb_hold;
  logic [`PIX_W-1:0] cr_hold;
  logic              skid_valid;

  wire               accept    = link.pixel_valid && link.pixel_ready;
  wire [1:0]         cur_pos   = link.group_first ? 2'h0 : pos;
  wire               even      = !cur_pos[0];
  wire [2:0]         fmt       = INPUT_FORMAT_SELECT;
  wire               reserved  = (fmt == `FMT_RESERVED);
  wire [`PIX_W-1:0]  pa        = link.pixel_port_a;
  wire [`PIX_W-1:0]  pb        = link.pixel_port_b;
  wire [`PIX_W-1:0]  pc        = link.pixel_port_c;
  wire               full_rate = (fmt == `FMT_YUV444) || (fmt == `FMT_RGB444);
  wire               indexed   = (fmt == `FMT_INDEXED);

  // full-rate formats pass B and C straight; subsampled ones use held pair
  wire [`PIX_W-1:0]  in_u = full_rate ? pb : (indexed ? 8'h00 : cb_hold);
  wire [`PIX_W-1:0]  in_v = full_rate ? pc : (indexed ? 8'h00 : cr_hold);
  wire               push = accept && !reserved;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      pos     <= 2'h0;
      cb_sh   <= 6'h00;
      cr_sh   <= 6'h00;
      cb_pend <= 8'h00;
      cb_hold <= 8'h00;
      cr_hold <= 8'h00;
    end else if (accept) begin
      pos <= cur_pos + 2'h1;
      unique case (fmt)
        `FMT_YUV411_SERIAL: begin
          cb_sh <= {cb_sh[3:0], pb[7:6]};
          cr_sh <= {cr_sh[3:0], pb[5:4]};
          if (cur_pos == 2'h3) begin
            cb_hold <= {cb_sh, pb[7:6]};
            cr_hold <= {cr_sh, pb[5:4]};
          end
        end
        `FMT_YUV411_WORD: begin
          if (cur_pos == 2'h0) begin
            cb_pend <= pb;
          end else if (cur_pos == 2'h2) begin
            cb_hold <= cb_pend;
            cr_hold <= pb;
          end
        end
        `FMT_YUV422_MUX: begin
          if (even) begin
            cb_pend <= pb;
          end else begin
            cb_hold <= cb_pend;
            cr_hold <= pb;
          end
        end
        `FMT_YUV422_PAR: begin
          if (even) begin
            cb_hold <= pb;
            cr_hold <= pc;
          end
        end
        default: begin
          cb_pend <= cb_pend;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // two-entry skid buffer toward the sample consumer
  // ---------------------------------------------------------------
  logic [`PIX_W-1:0] skid_y;
  logic [`PIX_W-1:0] skid_u;
  logic [`PIX_W-1:0] skid_v;

  wire               out_free = !SAMPLE_VALID || SAMPLE_READY;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      SAMPLE_VALID    <= 1'b0;
      SAMPLE_Y        <= 8'h00;
      SAMPLE_U        <= 8'h00;
      SAMPLE_V        <= 8'h00;
      SAMPLE_FORMAT   <= FMT_YUV411_SERIAL;
      FORMAT_RESERVED <= 1'b0;
      skid_valid      <= 1'b0;
      skid_y          <= 8'h00;
      skid_u          <= 8'h00;
      skid_v          <= 8'h00;
      link.pixel_ready <= 1'b0;
    end else begin
      FORMAT_RESERVED <= reserved;
      if (out_free) begin
        SAMPLE_VALID <= skid_valid || push;
        if (skid_valid) begin
          SAMPLE_Y   <= skid_y;
          SAMPLE_U   <= skid_u;
          SAMPLE_V   <= skid_v;
          skid_valid <= push;
        end else if (push) begin
          SAMPLE_Y      <= pa;
          SAMPLE_U      <= in_u;
          SAMPLE_V      <= in_v;
          SAMPLE_FORMAT <= fmt_t'(fmt);
        end
      end else if (push) begin
        skid_valid <= 1'b1;
      end
      if (push && (skid_valid || !out_free)) begin
        skid_y <= pa;
        skid_u <= in_u;
        skid_v <= in_v;
      end
      // ready drops on the same edge that fills the second entry and stays low while it is occupied
      link.pixel_ready <= !(skid_valid || (push && !out_free))
                          || (out_free && !skid_valid);
    end
  end

endmodule

// [testbench/pixel_link_props.sv]
`timescale 1ns/1ns
`include "video_in_defs.svh"

module pixel_link_props (
  // clock and reset
  input wire logic              CLK,
  input wire logic              RESET,
  // link signals
  input wire logic              pixel_valid,
  input wire logic              pixel_ready,
  input wire logic              group_first,
  input wire logic [`PIX_W-1:0] pixel_port_a,
  input wire logic [`PIX_W-1:0] pixel_port_b,
  input wire logic [`PIX_W-1:0] pixel_port_c,
  input wire logic [`RT_W-1:0]  realtime_control_input,
  input wire logic              realtime_strobe
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  // ----------------------------------------
  // group position of taken pixels
  // ----------------------------------------
  logic [1:0] pos;
  wire        taken = pixel_valid & pixel_ready;
  wire        stall = pixel_valid & ~pixel_ready;

  always_ff @(posedge CLK) begin
    if (RESET) pos <= 2'h0;
    else if (taken) pos <= group_first ? 2'h1 : pos + 2'h1;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_HOLD_VALID: assert property (stall |=> pixel_valid)
    else $error("pixel withdrawn before taken");
  AST_HOLD_LANES: assert property (stall |=>
    $stable({group_first, pixel_port_a, pixel_port_b, pixel_port_c}))
    else $error("lanes changed while refused");
  AST_READY_AFTER_RESET: assert property ($fell(RESET) |=> pixel_ready)
    else $error("encoder not ready after reset");
  AST_READY_IDLE: assert property (pixel_ready && !pixel_valid |=> pixel_ready)
    else $error("ready dropped with nothing taken");
  AST_READY_RETURNS: assert property (stall |-> ##[1:64] pixel_ready)
    else $error("encoder refused too long");
  AST_GROUP_POS: assert property (taken |-> group_first == (pos == 2'h0))
    else $error("group start out of step");
  AST_RT_PULSE: assert property (realtime_strobe |=> !realtime_strobe)
    else $error("real-time strobe longer than a cycle");
  AST_RT_WORD: assert property ($changed(realtime_control_input) |-> realtime_strobe)
    else $error("real-time word changed without strobe");

  cover property (taken && group_first);
  cover property (stall [*3]);
  cover property (realtime_strobe);
endmodule

// [testbench/tb_video_input_demux_and_subcarrier_select.sv]
`timescale 1ns/1ns
`include "video_in_defs.svh"

module tb_video_input_demux_and_subcarrier_select
  import video_in_pkg::*;
;
  localparam logic [21:0] RT_INC = 22'h3a5c71;

  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic [2:0]        fmt = 3'h4;
  logic              src_valid = 1'b0;
  logic              src_first = 1'b0;
  logic [7:0]        src_y = 8'h00;
  logic [7:0]        src_cb = 8'h00;
  logic [7:0]        src_cr = 8'h00;
  logic              rt_strobe = 1'b0;
  logic [21:0]       rt_word = 22'h0;
  logic              pal = 1'b1;
  logic              genlock = 1'b0;
  logic              slave = 1'b0;
  logic              realtime_control_enable = 1'b0;
  logic              realtime_subcarrier_select = 1'b0;
  logic [7:0]        offset = 8'h00;
  logic [7:0]        cpb = 8'h00;
  logic              field_start = 1'b0;
  logic              sample_ready = 1'b1;
  logic              hold_sink = 1'b0;
  logic              src_ready, sample_valid, fmt_reserved, phase_reset;
  logic [7:0]        sy, su, sv;
  logic [11:0]       sc_phase;
  fmt_t              sample_format;
  sc_src_t           sc_source;
  logic [24:0]       expq[$];
  logic [24:0]       got;
  logic [15:0]       held;
  logic              held_ok = 1'b0;
  logic [1:0]        pos = 2'h0;
  logic [1:0]        p;
  int                error_cnt = 0;
  int                samples_checked = 0;
  int                resets = 0;
  int                since = -1;
  wire               ext = slave & realtime_control_enable & realtime_subcarrier_select & ~genlock;

  initial forever #20 clk = ~clk;

  pixel_link_if pixel_link_if_inst ();
  pixel_source_end pixel_source_end_inst (.CLK(clk), .RESET(reset),
    .link(pixel_link_if_inst.source), .SRC_FORMAT(fmt), .SRC_VALID(src_valid),
    .SRC_READY(src_ready), .SRC_FIRST(src_first), .SRC_Y(src_y), .SRC_CB(src_cb),
    .SRC_CR(src_cr), .SRC_RT_STROBE(rt_strobe), .SRC_RT_WORD(rt_word));
  video_input_demux video_input_demux_inst (.CLK(clk), .RESET(reset),
    .link(pixel_link_if_inst.encoder), .INPUT_FORMAT_SELECT(fmt), .GENLOCK_MODE(genlock),
    .SLAVE_MODE(slave), .PAL_MODE(pal), .LINES_625_MODE(pal), .REALTIME_CONTROL_ENABLE(realtime_control_enable),
    .REALTIME_SUBCARRIER_SELECT(realtime_subcarrier_select), .SUBCARRIER_FREQ_OFFSET(offset),
    .CHROMA_PHASE_BYTE(cpb), .FIELD_START(field_start), .SAMPLE_VALID(sample_valid),
    .SAMPLE_READY(sample_ready), .SAMPLE_Y(sy), .SAMPLE_U(su), .SAMPLE_V(sv),
    .SAMPLE_FORMAT(sample_format), .FORMAT_RESERVED(fmt_reserved), .SC_PHASE(sc_phase),
    .SC_PHASE_RESET(phase_reset), .SC_SOURCE(sc_source));
  pixel_link_props pixel_link_props_inst (.CLK(clk), .RESET(reset),
    .pixel_valid(pixel_link_if_inst.pixel_valid), .pixel_ready(pixel_link_if_inst.pixel_ready),
    .group_first(pixel_link_if_inst.group_first), .pixel_port_a(pixel_link_if_inst.pixel_port_a),
    .pixel_port_b(pixel_link_if_inst.pixel_port_b), .pixel_port_c(pixel_link_if_inst.pixel_port_c),
    .realtime_control_input(pixel_link_if_inst.realtime_control_input),
    .realtime_strobe(pixel_link_if_inst.realtime_strobe));

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [24:0] pix_exp(input logic [2:0] f, input logic [7:0] y, cb, cr);
    case (f)
      3'h4, 3'h5: pix_exp = {1'b1, y, cb, cr};
      3'h7:       pix_exp = {1'b1, y, 16'h0};
      // no pair completed yet: chroma lanes are not compared, so expect zero there
      default:    pix_exp = {held_ok, y, held_ok ? held : 16'h0};
    endcase
  endfunction

  // chroma pair complete at this group position
  function automatic logic pair_done(input logic [2:0] f, input logic [1:0] q);
    case (f)
      3'h0:    pair_done = (q == 2'h3);
      3'h1:    pair_done = (q == 2'h2);
      3'h2:    pair_done = q[0];
      3'h3:    pair_done = !q[0];
      default: pair_done = 1'b0;
    endcase
  endfunction

  function automatic sc_src_t src_of(input logic g, s, e, r);
    if (g) return SC_GENLOCK;
    if (s && e) return r ? SC_EXTERNAL : SC_HPLL;
    return SC_INTERNAL;
  endfunction

  function automatic logic [11:0] ext_phase(input logic [7:0] c);
    return 12'((32'(RT_INC) * 16) >> 20) + {c, 4'h0};
  endfunction

  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    samples_checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // monitors
  // ----------------------------------------
  always @(posedge clk) sample_ready <= !hold_sink && ($urandom_range(3) != 0);

  always @(posedge clk) begin
    if (!reset && src_valid && src_ready) begin
      p = src_first ? 2'h0 : pos;
      if (fmt != 3'h6) expq.push_back(pix_exp(fmt, src_y, src_cb, src_cr));
      if (pair_done(fmt, p)) begin
        held = {src_cb, src_cr};
        held_ok = 1'b1;
      end
      pos = p + 2'h1;
    end
    if (!reset && sample_valid && sample_ready) begin
      if (expq.size() == 0) check(24'h1, 24'h0);
      else begin
        got = expq.pop_front();
        check({sy, got[24] ? {su, sv} : 16'h0}, got[23:0]);
        check(24'(sample_format), 24'(fmt));
      end
    end
  end

  // phase seen one cycle after each phase reset, and seventeen cycles after it when the external increment is selected
  always @(posedge clk) begin
    if (reset) since = -1;
    else if (phase_reset) begin
      resets++;
      since = 0;
    end
    else if (since >= 0) since++;
    if (since == 1) check(24'(sc_phase), 24'({cpb, 4'h0}));
    if (since == 17 && ext) check(24'(sc_phase), 24'(ext_phase(cpb)));
  end

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  // chroma is held per group so every packing carries the same pair
  task automatic send_groups(input int n);
    logic [7:0] cb, cr;
    for (int g = 0; g < n; g++) begin
      cb = 8'($urandom);
      cr = 8'($urandom);
      for (int i = 0; i < 4; i++) begin
        src_valid <= 1'b1;
        src_first <= (i == 0);
        src_y     <= 8'($urandom);
        src_cb    <= cb;
        src_cr    <= cr;
        @(posedge clk);
        while (!src_ready) @(posedge clk);
      end
    end
    src_valid <= 1'b0;
  endtask

  task automatic drain();
    int t = 0;
    while (expq.size() != 0 && t < 300) begin
      @(posedge clk);
      t++;
    end
    if (t >= 300) check(24'h1, 24'h0);
    repeat (8) @(posedge clk);
  endtask

  // m is {pal, genlock, slave, realtime_control_enable, realtime_subcarrier_select}; sixteen fields keep the field count aligned
  task automatic sc_trial(input logic [4:0] m, input logic [7:0] off, input int want);
    {pal, genlock, slave, realtime_control_enable, realtime_subcarrier_select} <= m;
    offset    <= off;
    cpb       <= 8'($urandom);
    rt_strobe <= 1'b1;
    rt_word   <= RT_INC;
    @(posedge clk);
    rt_strobe <= 1'b0;
    resets = 0;
    repeat (3) @(posedge clk);
    check(24'(sc_source), 24'(src_of(m[3], m[2], m[1], m[0])));
    for (int i = 0; i < 16; i++) begin
      field_start <= 1'b1;
      @(posedge clk);
      field_start <= 1'b0;
      repeat (40) @(posedge clk);
    end
    check(24'(resets), 24'(want));
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'ha21471e9));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int f = 0; f < 8; f++) begin
      fmt <= 3'(f);
      held_ok = 1'b0;
      @(posedge clk);
      send_groups(6);
      drain();
      check(24'(fmt_reserved), 24'(f == 6));
    end
    fmt <= 3'h4;
    hold_sink <= 1'b1;
    fork
      send_groups(2);
    join_none
    repeat (12) @(posedge clk);
    check(24'(src_ready), 24'h0);
    hold_sink <= 1'b0;
    wait fork;
    drain();
    sc_trial(5'b10000, 8'h00, 2);
    sc_trial(5'b00000, 8'h00, 4);
    sc_trial(5'b10000, 8'h05, 0);
    sc_trial(5'b00111, 8'h00, 4);
    sc_trial(5'b10110, 8'h00, 2);
    sc_trial(5'b10111, 8'h10, 0);
    sc_trial(5'b10110, 8'hf0, 0);
    sc_trial(5'b10010, 8'h00, 2);
    sc_trial(5'b11111, 8'h00, 0);
    print_verdict();
  end
endmodule
